// [hw/pilc_defs.vh]
// Constants of the parallel I/O line controller.
// Assumes inclusion by bare name from the design files.
`ifndef PILC_DEFS_VH
`define PILC_DEFS_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define PILC_OFS_LINE_OWN_SET 8'h00
`define PILC_OFS_LINE_OWN_CLEAR 8'h04
`define PILC_OFS_LINE_OWN_STATE 8'h08
`define PILC_OFS_DRIVE_ON 8'h10
`define PILC_OFS_DRIVE_OFF 8'h14
`define PILC_OFS_DRIVE_STATE 8'h18
`define PILC_OFS_DEGLITCH_ON 8'h20
`define PILC_OFS_DEGLITCH_OFF 8'h24
`define PILC_OFS_DEGLITCH_STATE 8'h28
`define PILC_OFS_OUT_LEVEL_SET 8'h30
`define PILC_OFS_OUT_LEVEL_CLEAR 8'h34
`define PILC_OFS_OUT_LEVEL_STATE 8'h38
`define PILC_OFS_PIN_LEVEL_STATE 8'h3c
`define PILC_OFS_IRQ_ON 8'h40
`define PILC_OFS_IRQ_OFF 8'h44
`define PILC_OFS_IRQ_MASK 8'h48
`define PILC_OFS_IRQ_PENDING 8'h4c
`define PILC_OFS_OPEN_DRAIN_ON 8'h50
`define PILC_OFS_OPEN_DRAIN_OFF 8'h54
`define PILC_OFS_OPEN_DRAIN_STATE 8'h58
`define PILC_OFS_PULLUP_OFF 8'h60
`define PILC_OFS_PULLUP_ON 8'h64
`define PILC_OFS_PULLUP_STATE 8'h68
`define PILC_OFS_PERIPH_A_SELECT 8'h70
`define PILC_OFS_PERIPH_B_SELECT 8'h74
`define PILC_OFS_PERIPH_SEL_STATE 8'h78
`define PILC_OFS_WMASK_SET 8'ha0
`define PILC_OFS_WMASK_CLEAR 8'ha4
`define PILC_OFS_WMASK_STATE 8'ha8

// ----------------------------------------
// Reset values and product masks
// ----------------------------------------
`define PILC_RST_ZERO 32'h00000000
`define PILC_DEF_LINE_MASK 32'hffffffff
`define PILC_DEF_MUX_MASK 32'hffffffff
`define PILC_DEF_OWN_RESET 32'hffffffff

// ----------------------------------------
// Bus answers
// ----------------------------------------
`define PILC_RESP_OKAY 2'b00
`define PILC_RESP_SLVERR 2'b10

`endif

// [hw/pilc_deglitch.v]
// Pin synchroniser and half-cycle glitch filter for 32 lines.
// Assumes raw pad levels that are asynchronous to clk.
`timescale 1ns/1ps
module pilc_deglitch (
    clk,
    rst_n,
    pin_raw,
    filt_on,
    sync_lvl,
    filt_lvl
);
    input wire clk;
    input wire rst_n;
    input wire [31:0] pin_raw;
    input wire [31:0] filt_on;
    output wire [31:0] sync_lvl;
    output wire [31:0] filt_lvl;

    reg [31:0] p1_ff;
    reg [31:0] p2_ff;
    reg [31:0] n1_ff;
    reg [31:0] n2_ff;
    reg [31:0] flt_ff;
    wire [31:0] differ;

    // ----------------------------------------
    // Rising and falling edge synchronisers
    // ----------------------------------------
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            p1_ff <= 32'h00000000;
            p2_ff <= 32'h00000000;
        end else begin
            p1_ff <= pin_raw;
            p2_ff <= p1_ff;
        end
    end

    always @(negedge clk or negedge rst_n) begin
        if (!rst_n) begin
            n1_ff <= 32'h00000000;
            n2_ff <= 32'h00000000;
        end else begin
            n1_ff <= pin_raw;
            n2_ff <= n1_ff;
        end
    end

    // ----------------------------------------
    // Accept a level only if both half-cycle samples agree
    // ----------------------------------------
    assign differ = p2_ff ^ n2_ff;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flt_ff <= 32'h00000000;
        end else begin
            flt_ff <= (~differ & p2_ff) | (differ & flt_ff);
        end
    end

    assign sync_lvl = p2_ff;
    assign filt_lvl = (filt_on & flt_ff) | (~filt_on & p2_ff);
endmodule

// [hw/pilc_top.v]
// Parallel I/O line controller: 32 lines, AXI4-Lite register slave.
// Assumes peripheral and power-manager inputs are on clk; pads are not.
`timescale 1ns/1ps
`include "pilc_defs.vh"
module pilc_top #(
    parameter [31:0] LINE_MASK = `PILC_DEF_LINE_MASK,
    parameter [31:0] MUX_MASK = `PILC_DEF_MUX_MASK,
    parameter [31:0] OWN_RESET = `PILC_DEF_OWN_RESET
) (
    input wire clk,
    input wire rst_n,
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire master_clk_on,
    input wire [31:0] pin_in,
    output reg [31:0] pin_out_ff,
    output reg [31:0] pin_oe_n_ff,
    output reg [31:0] pullup_on_ff,
    input wire [31:0] periph_a_out,
    input wire [31:0] periph_a_oe,
    input wire [31:0] periph_b_out,
    input wire [31:0] periph_b_oe,
    output reg [31:0] periph_in_ff,
    output reg change_irq_ff
);

    // ----------------------------------------
    // Shared helpers
    // ----------------------------------------
    function [31:0] strb_bits;
        input [3:0] s;
        begin
            strb_bits = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
        end
    endfunction

    // Set/clear update restricted to implemented lines
    function [31:0] set_clr;
        input [31:0] cur;
        input do_set;
        input do_clr;
        input [31:0] d;
        reg [31:0] r;
        begin
            r = cur;
            if (do_set) begin
                r = r | d;
            end
            if (do_clr) begin
                r = r & ~d;
            end
            set_clr = r & LINE_MASK;
        end
    endfunction

    // ----------------------------------------
    // State
    // ----------------------------------------
    reg [31:0] pullup_state_ff;
    reg [31:0] line_own_ff;
    reg [31:0] periph_sel_state_ff;
    reg [31:0] drive_state_ff;
    reg [31:0] out_level_state_ff;
    reg [31:0] wmask_state_ff;
    reg [31:0] open_drain_state_ff;
    reg [31:0] deglitch_state_ff;
    reg [31:0] change_irq_mask_ff;
    reg [31:0] change_irq_pending_ff;
    reg [31:0] pin_level_state_ff;
    reg [7:0] waddr_ff;
    reg [31:0] wdata_ff;
    reg [3:0] wstrb_ff;
    reg aw_hold_ff;
    reg w_hold_ff;
    reg [31:0] nxt_pending;
    reg [31:0] nxt_rdata;
    reg nxt_rhit;

    wire [31:0] sync_lvl;
    wire [31:0] filt_lvl;
    wire [31:0] line_own_state;
    wire [31:0] wd;
    wire wr_go;
    wire rd_go;
    wire [31:0] change;
    wire [31:0] sel_out;
    wire [31:0] sel_oe;
    wire [31:0] drv_lvl;
    wire [31:0] drv_en;

    assign line_own_state = (line_own_ff | ~MUX_MASK) & LINE_MASK;
    assign wd = wdata_ff & strb_bits(wstrb_ff);
    assign wr_go = aw_hold_ff & w_hold_ff & ~s_axi_bvalid;
    assign rd_go = s_axi_arvalid & s_axi_arready;

    pilc_deglitch u_deglitch (
        .clk(clk),
        .rst_n(rst_n),
        .pin_raw(pin_in),
        .filt_on(deglitch_state_ff),
        .sync_lvl(sync_lvl),
        .filt_lvl(filt_lvl)
    );

    // ----------------------------------------
    // Write channel
    // ----------------------------------------
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `PILC_RESP_OKAY;
            aw_hold_ff <= 1'b0;
            w_hold_ff <= 1'b0;
            waddr_ff <= 8'h00;
            wdata_ff <= 32'h00000000;
            wstrb_ff <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                waddr_ff <= s_axi_awaddr;
                aw_hold_ff <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wdata_ff <= s_axi_wdata;
                wstrb_ff <= s_axi_wstrb;
                w_hold_ff <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (wr_go) begin
                aw_hold_ff <= 1'b0;
                w_hold_ff <= 1'b0;
                s_axi_bvalid <= 1'b1;
                case (waddr_ff)
                    `PILC_OFS_LINE_OWN_SET, `PILC_OFS_LINE_OWN_CLEAR,
                    `PILC_OFS_DRIVE_ON, `PILC_OFS_DRIVE_OFF,
                    `PILC_OFS_DEGLITCH_ON, `PILC_OFS_DEGLITCH_OFF,
                    `PILC_OFS_OUT_LEVEL_SET, `PILC_OFS_OUT_LEVEL_CLEAR,
                    `PILC_OFS_OUT_LEVEL_STATE, `PILC_OFS_IRQ_ON,
                    `PILC_OFS_IRQ_OFF, `PILC_OFS_OPEN_DRAIN_ON,
                    `PILC_OFS_OPEN_DRAIN_OFF, `PILC_OFS_PULLUP_OFF,
                    `PILC_OFS_PULLUP_ON, `PILC_OFS_PERIPH_A_SELECT,
                    `PILC_OFS_PERIPH_B_SELECT, `PILC_OFS_WMASK_SET,
                    `PILC_OFS_WMASK_CLEAR, `PILC_OFS_LINE_OWN_STATE,
                    `PILC_OFS_DRIVE_STATE, `PILC_OFS_DEGLITCH_STATE,
                    `PILC_OFS_PIN_LEVEL_STATE, `PILC_OFS_IRQ_MASK,
                    `PILC_OFS_IRQ_PENDING, `PILC_OFS_OPEN_DRAIN_STATE,
                    `PILC_OFS_PULLUP_STATE, `PILC_OFS_PERIPH_SEL_STATE,
                    `PILC_OFS_WMASK_STATE: begin
                        s_axi_bresp <= `PILC_RESP_OKAY;
                    end
                    default: begin
                        s_axi_bresp <= `PILC_RESP_SLVERR;
                    end
                endcase
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // ----------------------------------------
    // Configuration registers
    // ----------------------------------------
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pullup_state_ff <= `PILC_RST_ZERO;
            line_own_ff <= OWN_RESET & LINE_MASK;
            periph_sel_state_ff <= `PILC_RST_ZERO;
            drive_state_ff <= `PILC_RST_ZERO;
            out_level_state_ff <= `PILC_RST_ZERO;
            wmask_state_ff <= `PILC_RST_ZERO;
            open_drain_state_ff <= `PILC_RST_ZERO;
            deglitch_state_ff <= `PILC_RST_ZERO;
            change_irq_mask_ff <= `PILC_RST_ZERO;
        end else if (wr_go) begin
            pullup_state_ff <= set_clr(pullup_state_ff,
                waddr_ff == `PILC_OFS_PULLUP_OFF,
                waddr_ff == `PILC_OFS_PULLUP_ON, wd);
            line_own_ff <= set_clr(line_own_ff,
                waddr_ff == `PILC_OFS_LINE_OWN_SET,
                waddr_ff == `PILC_OFS_LINE_OWN_CLEAR, wd & MUX_MASK);
            periph_sel_state_ff <= set_clr(periph_sel_state_ff,
                waddr_ff == `PILC_OFS_PERIPH_B_SELECT,
                waddr_ff == `PILC_OFS_PERIPH_A_SELECT, wd);
            drive_state_ff <= set_clr(drive_state_ff,
                waddr_ff == `PILC_OFS_DRIVE_ON,
                waddr_ff == `PILC_OFS_DRIVE_OFF, wd);
            wmask_state_ff <= set_clr(wmask_state_ff,
                waddr_ff == `PILC_OFS_WMASK_SET,
                waddr_ff == `PILC_OFS_WMASK_CLEAR, wd);
            open_drain_state_ff <= set_clr(open_drain_state_ff,
                waddr_ff == `PILC_OFS_OPEN_DRAIN_ON,
                waddr_ff == `PILC_OFS_OPEN_DRAIN_OFF, wd);
            deglitch_state_ff <= set_clr(deglitch_state_ff,
                waddr_ff == `PILC_OFS_DEGLITCH_ON,
                waddr_ff == `PILC_OFS_DEGLITCH_OFF, wd);
            change_irq_mask_ff <= set_clr(change_irq_mask_ff,
                waddr_ff == `PILC_OFS_IRQ_ON,
                waddr_ff == `PILC_OFS_IRQ_OFF, wd);
            if (waddr_ff == `PILC_OFS_OUT_LEVEL_STATE) begin
                // Only strobed bits whose wmask_state_ff bit is set take the new value
                out_level_state_ff <= ((out_level_state_ff & ~(wmask_state_ff
                    & strb_bits(wstrb_ff))) | (wdata_ff & wmask_state_ff
                    & strb_bits(wstrb_ff))) & LINE_MASK;
            end else begin
                out_level_state_ff <= set_clr(out_level_state_ff,
                    waddr_ff == `PILC_OFS_OUT_LEVEL_SET,
                    waddr_ff == `PILC_OFS_OUT_LEVEL_CLEAR, wd);
            end
        end
    end

    // ----------------------------------------
    // Pin sampling and change detection
    // ----------------------------------------
    assign change = master_clk_on ?
        ((filt_lvl ^ pin_level_state_ff) & LINE_MASK) : 32'h00000000;

    always @* begin
        nxt_pending = change_irq_pending_ff;
        if (rd_go && s_axi_araddr == `PILC_OFS_IRQ_PENDING) begin
            nxt_pending = 32'h00000000;
        end
        nxt_pending = nxt_pending | change;
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_level_state_ff <= `PILC_RST_ZERO;
            change_irq_pending_ff <= `PILC_RST_ZERO;
            change_irq_ff <= 1'b0;
            periph_in_ff <= 32'h00000000;
        end else begin
            if (master_clk_on) begin
                pin_level_state_ff <= filt_lvl & LINE_MASK;
            end
            change_irq_pending_ff <= nxt_pending;
            change_irq_ff <= |(nxt_pending & change_irq_mask_ff);
            periph_in_ff <= sync_lvl;
        end
    end

    // ----------------------------------------
    // Pad drive
    // ----------------------------------------
    assign sel_out = (periph_sel_state_ff & periph_b_out)
        | (~periph_sel_state_ff & periph_a_out);
    assign sel_oe = (periph_sel_state_ff & periph_b_oe)
        | (~periph_sel_state_ff & periph_a_oe);
    assign drv_lvl = (line_own_state & out_level_state_ff)
        | (~line_own_state & sel_out);
    assign drv_en = ((line_own_state & drive_state_ff)
        | (~line_own_state & sel_oe)) & LINE_MASK;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_out_ff <= 32'h00000000;
            pin_oe_n_ff <= 32'hffffffff;
            pullup_on_ff <= 32'hffffffff;
        end else begin
            pin_out_ff <= drv_lvl & ~open_drain_state_ff;
            pin_oe_n_ff <= ~(drv_en & ~(open_drain_state_ff & drv_lvl));
            pullup_on_ff <= ~pullup_state_ff;
        end
    end

    // ----------------------------------------
    // Read channel
    // ----------------------------------------
    always @* begin
        nxt_rhit = 1'b1;
        case (s_axi_araddr)
            `PILC_OFS_LINE_OWN_STATE: nxt_rdata = line_own_state;
            `PILC_OFS_DRIVE_STATE: nxt_rdata = drive_state_ff;
            `PILC_OFS_DEGLITCH_STATE: nxt_rdata = deglitch_state_ff;
            `PILC_OFS_OUT_LEVEL_STATE: nxt_rdata = out_level_state_ff;
            `PILC_OFS_PIN_LEVEL_STATE: nxt_rdata = pin_level_state_ff;
            `PILC_OFS_IRQ_MASK: nxt_rdata = change_irq_mask_ff;
            `PILC_OFS_IRQ_PENDING: nxt_rdata = change_irq_pending_ff;
            `PILC_OFS_OPEN_DRAIN_STATE: nxt_rdata = open_drain_state_ff;
            `PILC_OFS_PULLUP_STATE: nxt_rdata = pullup_state_ff;
            `PILC_OFS_PERIPH_SEL_STATE: nxt_rdata = periph_sel_state_ff;
            `PILC_OFS_WMASK_STATE: nxt_rdata = wmask_state_ff;
            `PILC_OFS_LINE_OWN_SET, `PILC_OFS_LINE_OWN_CLEAR,
            `PILC_OFS_DRIVE_ON, `PILC_OFS_DRIVE_OFF,
            `PILC_OFS_DEGLITCH_ON, `PILC_OFS_DEGLITCH_OFF,
            `PILC_OFS_OUT_LEVEL_SET, `PILC_OFS_OUT_LEVEL_CLEAR,
            `PILC_OFS_IRQ_ON, `PILC_OFS_IRQ_OFF,
            `PILC_OFS_OPEN_DRAIN_ON, `PILC_OFS_OPEN_DRAIN_OFF,
            `PILC_OFS_PULLUP_OFF, `PILC_OFS_PULLUP_ON,
            `PILC_OFS_PERIPH_A_SELECT, `PILC_OFS_PERIPH_B_SELECT,
            `PILC_OFS_WMASK_SET, `PILC_OFS_WMASK_CLEAR: nxt_rdata = 32'h00000000;
            default: begin
                nxt_rdata = 32'h00000000;
                nxt_rhit = 1'b0;
            end
        endcase
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `PILC_RESP_OKAY;
        end else begin
            if (rd_go) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= nxt_rdata & LINE_MASK;
                s_axi_rresp <= nxt_rhit ? `PILC_RESP_OKAY : `PILC_RESP_SLVERR;
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

endmodule

// [tb/pilc_pad_model.sv]
// Pads and two peripheral functions facing the I/O line controller.
// Assumes the bench picks which undriven lines it holds.
`timescale 1ns/1ps
module pilc_pad_model (
    input wire [31:0] pin_out,
    input wire [31:0] pin_oe_n,
    input wire [31:0] pullup_on,
    input wire [31:0] ext_en,
    input wire [31:0] ext_val,
    input wire [7:0] glitch_ns,
    input wire glitch_go,
    output wire [31:0] pin_in,
    output wire [31:0] periph_a_out,
    output wire [31:0] periph_a_oe,
    output wire [31:0] periph_b_out,
    output wire [31:0] periph_b_oe
);
    reg g = 1'b0;
    wire [31:0] flt;
    assign periph_a_out = 32'h3c5a96e1;
    assign periph_a_oe = 32'hffffffff;
    assign periph_b_out = 32'hc3a5691e;
    assign periph_b_oe = 32'h0f0f0f0f;
    // Undriven line: pull-up, else inverse of drive
    assign flt = (ext_en & ext_val) | (~ext_en & (pullup_on | ~pin_out));
    assign pin_in = ((~pin_oe_n & pin_out) | (pin_oe_n & flt)) ^ {10'h0, {2{g}}, 20'h0};
    // Pulse on lines 20 and 21 across a rising edge
    always @(posedge glitch_go) begin
        #20 g = 1'b1;
        #(glitch_ns) g = 1'b0;
    end
endmodule

// [tb/pilc_top_asserts.sv]
// Port-level checker for the I/O line controller.
// Assumes binding to pilc_top; pads settle between edges.
`timescale 1ns/1ps
`include "pilc_defs.vh"
module pilc_top_asserts (
    input wire clk,
    input wire rst_n,
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire s_axi_rvalid,
    input wire master_clk_on,
    input wire [31:0] pin_in,
    input wire [31:0] pin_oe_n_ff,
    input wire [31:0] pullup_on_ff,
    input wire [31:0] periph_in_ff,
    input wire change_irq_ff
);
    reg [1:0] up_ff;
    reg [3:0] stab_ff;
    reg [31:0] pin_q_ff;
    wire wr_hs = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    wire ar_hs = s_axi_arvalid && s_axi_arready;
    // ----------------------------------------
    // Cycles since reset and last pin change
    // ----------------------------------------
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            up_ff <= 2'd0;
            stab_ff <= 4'd0;
            pin_q_ff <= 32'h0;
        end else begin
            up_ff <= (up_ff == 2'd3) ? 2'd3 : up_ff + 2'd1;
            pin_q_ff <= pin_in;
            if (pin_in != pin_q_ff || !master_clk_on)
                stab_ff <= 4'd0;
            else if (stab_ff != 4'hf)
                stab_ff <= stab_ff + 4'd1;
        end
    end
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    AST_B_AFTER_WRITE: assert property (wr_hs |-> ##2 s_axi_bvalid && !s_axi_awready)
        else $error("write answer late");
    AST_UNMAPPED: assert property (wr_hs && s_axi_awaddr >= 8'hac |-> ##2
        s_axi_bresp == `PILC_RESP_SLVERR) else $error("unmapped write not refused");
    AST_AR_ANSWER: assert property (ar_hs |=> s_axi_rvalid && !s_axi_arready)
        else $error("read answer late");
    AST_B_STANDS: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
    AST_RESET_PADS: assert property (disable iff (1'b0) !rst_n |->
        pullup_on_ff == 32'hffffffff && pin_oe_n_ff == 32'hffffffff)
        else $error("pads wrong in reset");
    AST_PERIPH_RAW: assert property (up_ff == 2'd3 |->
        periph_in_ff == $past(pin_in, 3)) else $error("periph input not raw");
    AST_PEND_CLEAR: assert property (ar_hs && s_axi_araddr == `PILC_OFS_IRQ_PENDING
        && stab_ff >= 4'd8 |=> !change_irq_ff) else $error("irq kept after read");
    AST_IRQ_CAUSE: assert property ($rose(change_irq_ff) |->
        stab_ff < 4'd8 || s_axi_bvalid || $past(s_axi_bvalid))
        else $error("irq without pin change");
endmodule

// [tb/testbench.sv]
// Register-level bench for the I/O line controller.
// Assumes design, pad model and checker are compiled first.
`timescale 1ns/1ps
`include "pilc_defs.vh"
module testbench;
    localparam [31:0] LM = 32'h7fffffff;
    reg clk = 1'b0;
    reg rst_n = 1'b1;
    reg [7:0] awaddr = 8'h00;
    reg [7:0] araddr = 8'h00;
    reg [31:0] wdata = 32'h0;
    reg awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    reg clk_on = 1'b1, g_go = 1'b0;
    reg [31:0] ext_en = 32'h0, ext_val = 32'h0;
    reg [7:0] g_ns = 8'd10;
    reg [1:0] resp;
    reg [31:0] rdat;
    wire awready, wready, bvalid, arready, rvalid, irq;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata, pin_in, pout, poe_n, pu, pin_p, pao, pae, pbo, pbe;
    integer bad_count = 0;
    integer samples_checked = 0;
    always #12.5 clk = ~clk;
    pilc_top #(.LINE_MASK(LM), .MUX_MASK(32'h3fffffff), .OWN_RESET(32'hfffffffe)) uut (
        .clk(clk), .rst_n(rst_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .master_clk_on(clk_on), .pin_in(pin_in), .pin_out_ff(pout), .pin_oe_n_ff(poe_n),
        .pullup_on_ff(pu), .periph_a_out(pao), .periph_a_oe(pae), .periph_b_out(pbo),
        .periph_b_oe(pbe), .periph_in_ff(pin_p), .change_irq_ff(irq));
    pilc_pad_model pads (.pin_out(pout), .pin_oe_n(poe_n), .pullup_on(pu), .ext_en(ext_en),
        .ext_val(ext_val), .glitch_ns(g_ns), .glitch_go(g_go), .pin_in(pin_in),
        .periph_a_out(pao), .periph_a_oe(pae), .periph_b_out(pbo), .periph_b_oe(pbe));
    // ----------------------------------------
    // Bus and compare tasks
    // ----------------------------------------
    task chk(input [31:0] got, input [31:0] exp);
        begin
            samples_checked = samples_checked + 1;
            if (got !== exp) begin
                bad_count = bad_count + 1;
                $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    task wr(input [7:0] a, input [31:0] d);
        begin
            @(posedge clk);
            awaddr <= a;
            wdata <= d;
            awvalid <= 1'b1;
            wvalid <= 1'b1;
            bready <= 1'b1;
            do begin
                @(posedge clk);
                if (awready) awvalid <= 1'b0;
                if (wready) wvalid <= 1'b0;
            end while (!bvalid);
            resp = bresp;
            bready <= 1'b0;
        end
    endtask
    task rd(input [7:0] a);
        begin
            @(posedge clk);
            araddr <= a;
            arvalid <= 1'b1;
            rready <= 1'b1;
            do begin
                @(posedge clk);
                if (arready) arvalid <= 1'b0;
            end while (!rvalid);
            rdat = rdata;
            resp = rresp;
            rready <= 1'b0;
        end
    endtask
    task rdc(input [7:0] a, input [31:0] e);
        begin
            rd(a);
            chk(rdat, e);
        end
    endtask
    // Expected pad drive from the rules
    task pads_chk(input [31:0] own, sel, drv, lvl, od);
        reg [31:0] v, e;
        begin
            v = (own & lvl) | (~own & ((sel & pbo) | (~sel & pao)));
            e = (own & drv) | (~own & ((sel & pbe) | (~sel & pae)));
            chk(pout & LM, v & ~od & LM);
            chk(poe_n & LM, ~(e & ~(od & v)) & LM);
        end
    endtask
    task test_done;
        begin
            if (bad_count == 0 && samples_checked > 0)
                $display("DONE - PASS");
            else
                $display("DONE - FAIL");
            $finish;
        end
    endtask
    initial begin
        #200000;
        bad_count = bad_count + 1;
        test_done;
    end
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        rst_n <= 1'b0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        rdc(`PILC_OFS_LINE_OWN_STATE, 32'h7ffffffe);
        rdc(`PILC_OFS_PULLUP_STATE, 32'h0);
        rdc(`PILC_OFS_PERIPH_SEL_STATE, 32'h0);
        rdc(`PILC_OFS_WMASK_STATE, 32'h0);
        rdc(`PILC_OFS_OPEN_DRAIN_STATE, 32'h0);
        rdc(`PILC_OFS_DRIVE_STATE, 32'h0);
        rdc(`PILC_OFS_DEGLITCH_STATE, 32'h0);
        rdc(`PILC_OFS_IRQ_MASK, 32'h0);
        pads_chk(32'h7ffffffe, 32'h0, 32'h0, 32'h0, 32'h0);
        wr(8'hac, 32'hffffffff);
        chk(resp, `PILC_RESP_SLVERR);
        rdc(8'hac, 32'h0);
        chk(resp, `PILC_RESP_SLVERR);
        wr(`PILC_OFS_PULLUP_OFF, 32'hffffffff);
        rdc(`PILC_OFS_PULLUP_STATE, LM);
        wr(`PILC_OFS_PULLUP_ON, 32'h0000ffff);
        rdc(`PILC_OFS_PULLUP_STATE, 32'h7fff0000);
        chk(pu & LM, 32'h0000ffff);
        wr(`PILC_OFS_PERIPH_B_SELECT, 32'h00ff00ff);
        wr(`PILC_OFS_PERIPH_A_SELECT, 32'h000000ff);
        rdc(`PILC_OFS_PERIPH_SEL_STATE, 32'h00ff0000);
        wr(`PILC_OFS_LINE_OWN_CLEAR, 32'hffffffff);
        rdc(`PILC_OFS_LINE_OWN_STATE, 32'h40000000);
        wr(`PILC_OFS_LINE_OWN_SET, 32'h0000ffff);
        rdc(`PILC_OFS_LINE_OWN_STATE, 32'h4000ffff);
        wr(`PILC_OFS_DRIVE_ON, 32'hffffffff);
        rdc(`PILC_OFS_DRIVE_STATE, LM);
        wr(`PILC_OFS_OUT_LEVEL_CLEAR, 32'hffffffff);
        wr(`PILC_OFS_OUT_LEVEL_SET, 32'h0000ff00);
        wr(`PILC_OFS_OUT_LEVEL_CLEAR, 32'h00000f00);
        rdc(`PILC_OFS_OUT_LEVEL_STATE, 32'h0000f000);
        wr(`PILC_OFS_WMASK_SET, 32'h000000ff);
        wr(`PILC_OFS_OUT_LEVEL_STATE, 32'hffff00a5);
        rdc(`PILC_OFS_OUT_LEVEL_STATE, 32'h0000f0a5);
        wr(`PILC_OFS_OPEN_DRAIN_ON, 32'h000000f0);
        rdc(`PILC_OFS_OPEN_DRAIN_STATE, 32'h000000f0);
        pads_chk(32'h4000ffff, 32'h00ff0000, LM, 32'h0000f0a5, 32'h000000f0);
        wr(`PILC_OFS_DRIVE_OFF, 32'hffffffff);
        wr(`PILC_OFS_LINE_OWN_SET, 32'hffffffff);
        ext_en <= 32'hffff0000;
        ext_val <= 32'hc3c30000;
        repeat (8) @(posedge clk);
        rdc(`PILC_OFS_PIN_LEVEL_STATE, 32'h43c3ffff);
        rd(`PILC_OFS_IRQ_PENDING);
        wr(`PILC_OFS_IRQ_ON, 32'h00010001);
        rdc(`PILC_OFS_IRQ_MASK, 32'h00010001);
        ext_val <= 32'hc3c10000;
        repeat (8) @(posedge clk);
        chk(irq, 32'h0);
        ext_val <= 32'hc3c00000;
        repeat (8) @(posedge clk);
        chk(irq, 32'h1);
        rdc(`PILC_OFS_IRQ_PENDING, 32'h00030000);
        chk(irq, 32'h0);
        rdc(`PILC_OFS_IRQ_PENDING, 32'h0);
        clk_on <= 1'b0;
        repeat (2) @(posedge clk);
        ext_val <= 32'hc3c40000;
        repeat (8) @(posedge clk);
        rdc(`PILC_OFS_PIN_LEVEL_STATE, 32'h43c0ffff);
        clk_on <= 1'b1;
        repeat (8) @(posedge clk);
        rdc(`PILC_OFS_PIN_LEVEL_STATE, 32'h43c4ffff);
        rdc(`PILC_OFS_IRQ_PENDING, 32'h00040000);
        wr(`PILC_OFS_DEGLITCH_ON, 32'h00100000);
        rdc(`PILC_OFS_DEGLITCH_STATE, 32'h00100000);
        g_go <= 1'b1;
        repeat (8) @(posedge clk);
        rdc(`PILC_OFS_IRQ_PENDING, 32'h00200000);
        g_go <= 1'b0;
        g_ns <= 8'd28;
        @(posedge clk);
        g_go <= 1'b1;
        repeat (8) @(posedge clk);
        rdc(`PILC_OFS_IRQ_PENDING, 32'h00300000);
        test_done;
    end
endmodule
bind pilc_top pilc_top_asserts chk_i (.clk(clk), .rst_n(rst_n), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .master_clk_on(master_clk_on),
    .pin_in(pin_in), .pin_oe_n_ff(pin_oe_n_ff), .pullup_on_ff(pullup_on_ff),
    .periph_in_ff(periph_in_ff), .change_irq_ff(change_irq_ff));
